/* verilog/aec_ctrl.sv */
// asynchronous event counter control, status and counters behind an apb slave
//
// Operation
// - high counter clock: 00 high pin, 01 div2, 10 div4, 11 div8
// - low counter clock: 00 low pin, 01 div2, 10 div4, 11 div8
// - gating pwm clock: div 2,4,8,16, then 32 or 64 with middle ignored
// - clock control bit 0 is reserved read/write, resets 0, never write 1
// - overflow flags accept only written 0; writing 1 leaves them unchanged
// - high overflow sets on high wrap; cleared by read as 1 then write 0
// - in cascade mode high overflow marks 16-bit wrap ffff to 0000
// - low overflow sets on low wrap only in split mode; read 1 then write 0
// - mode bit 0 cascades low overflow into high; 1 gives two counters
// - high count enable passes clocks when 1, holds value when 0
// - low count enable passes clocks when 1, holds value when 0
// - high reset control holds high counter at zero while 0
// - low reset control holds low counter at zero while 0
// - high counter is read-only 8-bit up-counter, zero at reset
// - low counter is read-only 8-bit up-counter, zero at reset
// - control/status clears to 00 at reset; bit 5 reserved read/write
// - pin edge codes: 00 falling, 01 rising, 10 both, 11 none
// - with pwm gating off, counters count only while gate pin high
// - with pwm gating on, counters count only while pwm output high
// - any overflow flag setting raises the counter interrupt request event; a cascaded low wrap does not
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "aec_defs.svh"

module aec_ctrl #(
    parameter int PRE_W = `AEC_PRE_W
) (
    input  wire logic        core_clk,          // system clock, 40 mhz
    input  wire logic        rst,               // async reset, active high
    input  wire logic        psel,              // apb select
    input  wire logic        penable,           // apb access phase
    input  wire logic        pwrite,            // apb write direction
    input  wire logic [11:0] paddr,             // apb byte address
    input  wire logic [31:0] pwdata,            // apb write data
    input  wire logic [3:0]  pstrb,             // apb byte strobes
    output logic      [31:0] prdata,            // apb read data
    output logic             pready,            // apb ready
    output logic             pslverr,           // apb error, unmapped address
    input  wire logic        high_event_pin,    // async event pin, high counter
    input  wire logic        low_event_pin,     // async event pin, low counter
    input  wire logic        external_gate_pin, // async gate pin
    input  wire logic        gating_pwm_output, // gating pwm waveform, same clock
    output logic             gate_pwm_tick,     // gating pwm clock enable pulse
    output logic             gating_pwm_enable, // pwm gating selected
    output logic             counter_irq_event  // overflow pulse to request flag
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    aec_pkg::aec_state_t q;
    aec_pkg::aec_state_t d;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // one-cycle pulse every 2**k cycles of the free prescaler
    function automatic logic div_tick(input logic [PRE_W-1:0] pre, input int k);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < PRE_W; i++) begin
            if (i < k && !pre[i]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic pin_edge(input logic [1:0] code, input logic prev,
                                      input logic cur);
        logic e;
        e = 1'b0;
        case (code)
            `AEC_EDGE_FALL: e = prev & ~cur;
            `AEC_EDGE_RISE: e = ~prev & cur;
            `AEC_EDGE_BOTH: e = prev ^ cur;
            default:        e = 1'b0;
        endcase
        return e;
    endfunction

    // counter source mux shared by both halves
    function automatic logic src_tick(input logic [1:0] sel, input logic edge_hit,
                                      input logic [PRE_W-1:0] pre);
        logic t;
        t = 1'b0;
        case (sel)
            `AEC_SRC_PIN:  t = edge_hit;
            `AEC_SRC_DIV2: t = div_tick(pre, 1);
            `AEC_SRC_DIV4: t = div_tick(pre, 2);
            default:       t = div_tick(pre, 3);
        endcase
        return t;
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic       acc;
    logic       wr;
    logic       rd;
    logic       hit;
    logic [7:0] rdval;
    logic       gate;
    logic       cascade;
    logic       h_edge;
    logic       l_edge;
    logic       l_tick;
    logic       h_tick;
    logic       l_step;
    logic       h_step;
    logic       l_wrap;
    logic       h_wrap;
    logic       wr_cs;
    logic       clr_hi_ovf;
    logic       clr_lo_ovf;
    logic       set_hi_ovf;
    logic       set_lo_ovf;
    logic [2:0] pwm_sel;

    always_comb begin
        d = q;

        // apb: access completes in the second cycle of the access phase
        acc = psel & penable & q.pready;
        wr  = acc & pwrite;
        rd  = acc & ~pwrite;

        // address decode
        hit   = 1'b1;
        rdval = 8'h00;
        if (paddr == `AEC_OFF_CLK_CTL) begin
            rdval = q.clk_ctl;
        end else if (paddr == `AEC_OFF_CTL_STS) begin
            rdval = q.ctl_sts;
        end else if (paddr == `AEC_OFF_UPPER_CNT) begin
            rdval = q.upper_cnt;
        end else if (paddr == `AEC_OFF_LOWER_CNT) begin
            rdval = q.lower_cnt;
        end else if (paddr == `AEC_OFF_EDGE_SEL) begin
            rdval = q.edge_sel;
        end else begin
            hit = 1'b0;
        end

        d.pready  = psel & penable & ~q.pready;
        d.pslverr = psel & penable & ~q.pready & ~hit;
        if (psel & penable & ~q.pready) begin
            d.prdata = {24'h000000, (pwrite ? 8'h00 : rdval)};
        end

        // two-flop synchronisers, edges found on the second stage
        d.sync_h = {q.sync_h[0], high_event_pin};
        d.sync_l = {q.sync_l[0], low_event_pin};
        d.sync_g = {q.sync_g[0], external_gate_pin};
        d.prev_h = q.sync_h[1];
        d.prev_l = q.sync_l[1];
        h_edge = pin_edge(q.edge_sel[`AEC_ES_HEDGE_HI:`AEC_ES_HEDGE_LO],
                          q.prev_h, q.sync_h[1]);
        l_edge = pin_edge(q.edge_sel[`AEC_ES_LEDGE_HI:`AEC_ES_LEDGE_LO],
                          q.prev_l, q.sync_l[1]);

        d.pre = q.pre + 6'h01;

        pwm_sel = q.clk_ctl[`AEC_CC_PSEL_HI:`AEC_CC_PSEL_LO];
        if (pwm_sel[2]) begin
            d.pwm_tick = div_tick(q.pre, pwm_sel[0] ? 6 : 5);
        end else begin
            d.pwm_tick = div_tick(q.pre, int'(pwm_sel[1:0]) + 1);
        end

        gate = q.edge_sel[`AEC_ES_PWM_EN] ? gating_pwm_output : q.sync_g[1];

        // cascade when mode bit is 0
        cascade = ~q.ctl_sts[`AEC_CS_CASCADE];

        l_tick = src_tick(q.clk_ctl[`AEC_CC_LSEL_HI:`AEC_CC_LSEL_LO], l_edge, q.pre);
        l_step = l_tick & gate & q.ctl_sts[`AEC_CS_LCNT_EN] & q.ctl_sts[`AEC_CS_LRUN];
        l_wrap = l_step & (q.lower_cnt == `AEC_COUNT_MAX);

        // high clock: own source, or low overflow in cascade
        if (cascade) begin
            h_tick = l_wrap;
        end else begin
            h_tick = src_tick(q.clk_ctl[`AEC_CC_HSEL_HI:`AEC_CC_HSEL_LO], h_edge, q.pre)
                     & gate;
        end
        h_step = h_tick & q.ctl_sts[`AEC_CS_HCNT_EN] & q.ctl_sts[`AEC_CS_HRUN];
        h_wrap = h_step & (q.upper_cnt == `AEC_COUNT_MAX);

        if (!q.ctl_sts[`AEC_CS_LRUN]) begin
            d.lower_cnt = `AEC_RST_COUNT;
        end else if (l_step) begin
            d.lower_cnt = q.lower_cnt + 8'h01;
        end
        if (!q.ctl_sts[`AEC_CS_HRUN]) begin
            d.upper_cnt = `AEC_RST_COUNT;
        end else if (h_step) begin
            d.upper_cnt = q.upper_cnt + 8'h01;
        end

        // arm a clear when the flag was read as 1
        wr_cs = wr & (paddr == `AEC_OFF_CTL_STS) & pstrb[0];
        if (rd && paddr == `AEC_OFF_CTL_STS) begin
            d.arm_h = q.arm_h | q.ctl_sts[`AEC_CS_HOVF];
            d.arm_l = q.arm_l | q.ctl_sts[`AEC_CS_LOVF];
        end else if (wr_cs) begin
            d.arm_h = 1'b0;
            d.arm_l = 1'b0;
        end

        // clock control, bit 0 stored as written
        if (wr && paddr == `AEC_OFF_CLK_CTL && pstrb[0]) begin
            d.clk_ctl = pwdata[7:0];
        end
        if (wr && paddr == `AEC_OFF_EDGE_SEL && pstrb[0]) begin
            d.edge_sel = pwdata[7:0];
        end

        // control bits incl. reserved bit 5 are plain read/write
        if (wr_cs) begin
            d.ctl_sts[5:0] = pwdata[5:0];
        end

        // only a written 0 after an armed read clears a flag
        clr_hi_ovf = wr_cs & ~pwdata[`AEC_CS_HOVF] & q.arm_h;
        clr_lo_ovf = wr_cs & ~pwdata[`AEC_CS_LOVF] & q.arm_l;
        // high wrap, in cascade the 16-bit wrap
        set_hi_ovf = h_wrap;
        // low flag only in split mode
        set_lo_ovf = l_wrap & ~cascade;
        // set wins over a clear in the same cycle
        d.ctl_sts[`AEC_CS_HOVF] = set_hi_ovf | (q.ctl_sts[`AEC_CS_HOVF] & ~clr_hi_ovf);
        d.ctl_sts[`AEC_CS_LOVF] = set_lo_ovf | (q.ctl_sts[`AEC_CS_LOVF] & ~clr_lo_ovf);

        // overflow event toward the interrupt request flag
        d.ovf_event = h_wrap | set_lo_ovf;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q.clk_ctl   <= `AEC_RST_CLK_CTL;
            q.ctl_sts   <= `AEC_RST_CTL_STS;
            q.edge_sel  <= `AEC_RST_EDGE_SEL;
            q.upper_cnt <= `AEC_RST_COUNT;
            q.lower_cnt <= `AEC_RST_COUNT;
            q.pre       <= 6'h00;
            q.sync_h    <= 2'h0;
            q.sync_l    <= 2'h0;
            q.sync_g    <= 2'h0;
            q.prev_h    <= 1'b0;
            q.prev_l    <= 1'b0;
            q.arm_h     <= 1'b0;
            q.arm_l     <= 1'b0;
            q.pready    <= 1'b0;
            q.pslverr   <= 1'b0;
            q.prdata    <= 32'h00000000;
            q.pwm_tick  <= 1'b0;
            q.ovf_event <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata            = q.prdata;
    assign pready            = q.pready;
    assign pslverr           = q.pslverr;
    assign gate_pwm_tick     = q.pwm_tick;
    assign gating_pwm_enable = q.edge_sel[`AEC_ES_PWM_EN];
    assign counter_irq_event = q.ovf_event;

endmodule // aec_ctrl

`default_nettype wire

/* verilog/aec_defs.svh */
// constants of the asynchronous event counter control block
`ifndef AEC_DEFS_SVH
`define AEC_DEFS_SVH

// register byte offsets
`define AEC_OFF_CLK_CTL     12'h000
`define AEC_OFF_CTL_STS     12'h004
`define AEC_OFF_UPPER_CNT   12'h008
`define AEC_OFF_LOWER_CNT   12'h00c
`define AEC_OFF_EDGE_SEL    12'h010

// reset values
`define AEC_RST_CLK_CTL     8'h00
`define AEC_RST_CTL_STS     8'h00
`define AEC_RST_EDGE_SEL    8'h00
`define AEC_RST_COUNT       8'h00

// field positions, clock control
`define AEC_CC_HSEL_HI      7
`define AEC_CC_HSEL_LO      6
`define AEC_CC_LSEL_HI      5
`define AEC_CC_LSEL_LO      4
`define AEC_CC_PSEL_HI      3
`define AEC_CC_PSEL_LO      1

// field positions, control and status
`define AEC_CS_HOVF         7
`define AEC_CS_LOVF         6
`define AEC_CS_CASCADE      4
`define AEC_CS_HCNT_EN      3
`define AEC_CS_LCNT_EN      2
`define AEC_CS_HRUN         1
`define AEC_CS_LRUN         0

// field positions, edge select
`define AEC_ES_HEDGE_HI     7
`define AEC_ES_HEDGE_LO     6
`define AEC_ES_LEDGE_HI     5
`define AEC_ES_LEDGE_LO     4
`define AEC_ES_PWM_EN       1

// clock source codes and edge codes
`define AEC_SRC_PIN         2'h0
`define AEC_SRC_DIV2        2'h1
`define AEC_SRC_DIV4        2'h2
`define AEC_SRC_DIV8        2'h3
`define AEC_EDGE_FALL       2'h0
`define AEC_EDGE_RISE       2'h1
`define AEC_EDGE_BOTH       2'h2

// prescaler width covers the largest divide, 64
`define AEC_PRE_W           6
`define AEC_COUNT_MAX       8'hff

`endif

/* verilog/aec_pkg.sv */
// types of the asynchronous event counter control block
package aec_pkg;

    typedef struct packed {
        logic [7:0]  clk_ctl;
        logic [7:0]  ctl_sts;
        logic [7:0]  edge_sel;
        logic [7:0]  upper_cnt;
        logic [7:0]  lower_cnt;
        logic [5:0]  pre;
        logic [1:0]  sync_h;
        logic [1:0]  sync_l;
        logic [1:0]  sync_g;
        logic        prev_h;
        logic        prev_l;
        logic        arm_h;
        logic        arm_l;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        pwm_tick;
        logic        ovf_event;
    } aec_state_t;

endpackage

/* verif/aec_ctrl_sva.sv */
// port checker for the event counter control block
`timescale 1ns/100ps
`default_nettype none
`include "aec_defs.svh"
module aec_ctrl_sva (
    input wire logic        core_clk,          // clock
    input wire logic        rst,               // reset
    input wire logic        psel,              // apb select
    input wire logic        penable,           // apb enable
    input wire logic        pwrite,            // apb direction
    input wire logic [11:0] paddr,             // apb address
    input wire logic [31:0] pwdata,            // apb write data
    input wire logic [3:0]  pstrb,             // apb strobes
    input wire logic [31:0] prdata,            // apb read data
    input wire logic        pready,            // apb ready
    input wire logic        pslverr,           // apb error
    input wire logic        high_event_pin,    // event pin
    input wire logic        low_event_pin,     // event pin
    input wire logic        external_gate_pin, // gate pin
    input wire logic        gating_pwm_output, // pwm gate
    input wire logic        gate_pwm_tick,     // pwm clock pulse
    input wire logic        gating_pwm_enable, // pwm gating on
    input wire logic        counter_irq_event  // overflow pulse
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (rst);
// ----------------------------------------
// checks
// ----------------------------------------
a_rdy_timing: assert property (psel && penable && !pready && !$past(penable) |=> pready)
    else $error("ready not in second access cycle");
a_rdy_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
a_err_map: assert property (pready |-> pslverr == !(paddr == `AEC_OFF_CLK_CTL
    || paddr == `AEC_OFF_CTL_STS || paddr == `AEC_OFF_UPPER_CNT
    || paddr == `AEC_OFF_LOWER_CNT || paddr == `AEC_OFF_EDGE_SEL))
    else $error("error flag disagrees with address map");
a_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
a_rd_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
a_pwm_write: assert property (psel && penable && pready && pwrite && pstrb[0]
    && paddr == `AEC_OFF_EDGE_SEL |=> gating_pwm_enable == $past(pwdata[1]))
    else $error("pwm gating enable not taken from write");
a_pwm_hold: assert property (!(psel && penable && pwrite) |=> $stable(gating_pwm_enable))
    else $error("pwm gating enable moved without write");
a_tick_pulse: assert property (gate_pwm_tick |=> !gate_pwm_tick)
    else $error("pwm clock pulse too close");
a_irq_pulse: assert property (counter_irq_event |=> !counter_irq_event)
    else $error("overflow pulse longer than one cycle");
a_reset_out: assert property ($fell(rst) |-> !pready && !counter_irq_event && !gating_pwm_enable)
    else $error("outputs active after reset");
endmodule // aec_ctrl_sva
bind aec_ctrl aec_ctrl_sva aec_ctrl_sva_i (.*);
`default_nettype wire

/* verif/aec_event_src.sv */
// model of the external event sources on the pins
`timescale 1ns/100ps
`default_nettype none
module aec_event_src (
    input wire logic core_clk,          // paces the edges
    output logic     high_event_pin,    // event pin, high counter
    output logic     low_event_pin,     // event pin, low counter
    output logic     external_gate_pin, // gate level
    output logic     gating_pwm_output  // pwm gate level
);
initial begin
    high_event_pin = 1'b0;
    low_event_pin = 1'b0;
    external_gate_pin = 1'b1;
    gating_pwm_output = 1'b0;
end
// levels held 4 cycles, safely above the two-cycle minimum
task pulse(input int n);
    repeat (n) begin
        @(posedge core_clk);
        high_event_pin <= 1'b1;
        low_event_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        high_event_pin <= 1'b0;
        low_event_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
endtask
task set_gate(input logic g, input logic p);
    @(posedge core_clk);
    external_gate_pin <= g;
    gating_pwm_output <= p;
    repeat (4) @(posedge core_clk);
endtask
endmodule // aec_event_src
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the event counter control block
`timescale 1ns/100ps
`default_nettype none
`include "aec_defs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
localparam logic [11:0] CC = `AEC_OFF_CLK_CTL;
localparam logic [11:0] CS = `AEC_OFF_CTL_STS;
localparam logic [11:0] UC = `AEC_OFF_UPPER_CNT;
localparam logic [11:0] LC = `AEC_OFF_LOWER_CNT;
localparam logic [11:0] ES = `AEC_OFF_EDGE_SEL;
logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
logic high_event_pin, low_event_pin, external_gate_pin, gating_pwm_output;
logic gate_pwm_tick, gating_pwm_enable, counter_irq_event;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, v;
logic        err_v;
logic [3:0]  pstrb;
int errors, n_compared, irq_n;
aec_ctrl aec_ctrl_i (.*);
aec_event_src aec_event_src_i (.*);
initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
end
always @(posedge core_clk) if (counter_irq_event === 1'b1) irq_n <= irq_n + 1;
// ----------------------------------------
// bus access and verdict
// ----------------------------------------
task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    v = prdata;
    err_v = pslverr;
    psel <= 1'b0; penable <= 1'b0;
endtask
task wr(input logic [11:0] a, input logic [7:0] d); apb(1'b1, a, d); endtask
task rd(input logic [11:0] a); apb(1'b0, a, 8'h00); endtask
function logic near(input logic [7:0] g, input int e);
    return (g >= e) && (g <= e + 3);
endfunction
task results;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task t_regs;
    rd(CC); `CHK(v, 32'h0)
    `CHK(err_v, 1'b0)
    rd(CS); `CHK(v, 32'h0)
    rd(UC); `CHK(v, 32'h0)
    rd(LC); `CHK(v, 32'h0)
    wr(CC, 8'hfe); rd(CC); `CHK(v[7:0], 8'hfe)
    // lane 0 strobe low: the write must be ignored
    pstrb <= 4'he;
    wr(CC, 8'h12);
    pstrb <= 4'hf;
    rd(CC); `CHK(v[7:0], 8'hfe)
    wr(CS, 8'h20); rd(CS); `CHK(v[7:0], 8'h20)
    wr(UC, 8'h55); rd(UC); `CHK(v[7:0], 8'h00)
    rd(12'h014); `CHK(v, 32'h0)
    `CHK(err_v, 1'b1)
    wr(CS, 8'h00);
endtask
task t_pwm_clk;
    int n;
    for (int c = 0; c < 8; c++) begin
        wr(CC, {4'h0, 3'(c), 1'b0});
        repeat (2) do @(posedge core_clk); while (gate_pwm_tick !== 1'b1);
        n = 0;
        do begin @(posedge core_clk); n++; end while (gate_pwm_tick !== 1'b1);
        `CHK(n, c[2] ? (c[0] ? 64 : 32) : (2 << c[1:0]))
    end
endtask
task t_div;
    for (int c = 1; c < 4; c++) begin
        wr(CS, 8'h10); wr(CC, {2'(c), 2'(4 - c), 4'h0}); wr(CS, 8'h1f);
        repeat (128) @(posedge core_clk);
        wr(CS, 8'h13);
        rd(UC); `CHK(near(v[7:0], 128 >> c), 1'b1)
        rd(LC); `CHK(near(v[7:0], 128 >> (4 - c)), 1'b1)
    end
    wr(CC, 8'h00);
endtask
task t_pins;
    for (int e = 0; e < 4; e++) begin
        wr(CS, 8'h10); wr(ES, {2'(e), 2'(e), 4'h0}); wr(CS, 8'h1f);
        aec_event_src_i.pulse(3);
        rd(UC); `CHK(v[7:0], 8'(e == 2 ? 6 : e == 3 ? 0 : 3))
        rd(LC); `CHK(v[7:0], 8'(e == 2 ? 6 : e == 3 ? 0 : 3))
    end
    wr(ES, 8'ha0); aec_event_src_i.pulse(1);
    wr(CS, 8'h13); aec_event_src_i.pulse(2);
    rd(UC); `CHK(v[7:0], 8'h02)
    rd(LC); `CHK(v[7:0], 8'h02)
    wr(CS, 8'h1f); aec_event_src_i.set_gate(1'b0, 1'b0); aec_event_src_i.pulse(1);
    rd(LC); `CHK(v[7:0], 8'h02)
    `CHK(gating_pwm_enable, 1'b0)
    wr(ES, 8'ha2); aec_event_src_i.set_gate(1'b0, 1'b1);
    `CHK(gating_pwm_enable, 1'b1)
    aec_event_src_i.pulse(1);
    rd(LC); `CHK(v[7:0], 8'h04)
    aec_event_src_i.set_gate(1'b1, 1'b0); aec_event_src_i.pulse(1);
    rd(UC); `CHK(v[7:0], 8'h04)
    wr(ES, 8'h00);
    wr(CS, 8'h10);
    rd(UC); `CHK(v[7:0], 8'h00)
    rd(LC); `CHK(v[7:0], 8'h00)
endtask
task t_ovf;
    int n0;
    n0 = irq_n;
    wr(CC, 8'h50); wr(CS, 8'h1f);
    repeat (600) @(posedge core_clk);
    wr(CC, 8'h00);
    `CHK(irq_n > n0, 1'b1)
    rd(CS); `CHK(v[7:0], 8'hdf)
    wr(CS, 8'hdf); wr(CS, 8'h1f);
    rd(CS); `CHK(v[7:0], 8'hdf)
    wr(CS, 8'h1f);
    rd(CS); `CHK(v[7:0], 8'h1f)
endtask
task t_casc;
    wr(CS, 8'h00); wr(CC, 8'h10); wr(CS, 8'h0f);
    repeat (600) @(posedge core_clk);
    wr(CC, 8'h00);
    rd(UC); `CHK(v[7:0], 8'h01)
    rd(CS); `CHK(v[7:0], 8'h0f)
endtask
initial begin
    irq_n = 0; errors = 0; n_compared = 0;
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_regs; t_pwm_clk; t_div; t_pins; t_ovf; t_casc;
    results;
end
initial begin
    #2000000;
    errors++;
    results;
end
endmodule // tb_top
`default_nettype wire
